// [include/irq_route_pkg.sv]
package irq_route_pkg;

    // ****************************************************************
    // Register map
    // ****************************************************************
    localparam int ADDR_W = 12;
    localparam logic [11:0] OFS_ENABLE = 12'h604;
    localparam logic [11:0] OFS_ROUTE = 12'h608;

    // ****************************************************************
    // Reset values and field masks
    // ****************************************************************
    localparam logic [31:0] ENABLE_RESET = 32'h00000000;
    localparam logic [31:0] ROUTE_RESET = 32'h00000000;
    localparam logic [31:0] ENABLE_RW_MASK = 32'hFFFFDF00;
    localparam logic [31:0] ROUTE_RW_MASK = 32'hFF0F8F0F;
    localparam logic [31:0] ROUTE_FIXED = 32'h00102000;
    localparam logic [31:0] SOFT_SRC_MASK = 32'h0000000F;
    localparam logic [31:0] GATED_SRC_MASK = 32'hFFFFFF00;
    localparam logic [31:0] EXT_SRC_MASK = 32'hFF0FFF0F;

    // ****************************************************************
    // Bit positions
    // ****************************************************************
    localparam int B_PCI_ERRLOG = 31;
    localparam int B_LOCAL_ERRLOG = 30;
    localparam int B_MASTER_PARITY = 29;
    localparam int B_PCI_CFG_STATUS = 28;
    localparam int B_DMA_LOCAL_ERR = 27;
    localparam int B_DMA_PCI_ERR = 26;
    localparam int B_DMA_RESET = 25;
    localparam int B_DMA_DONE = 24;
    localparam int B_PASS_INT = 23;
    localparam int B_PASS_PARITY = 22;
    localparam int B_PASS_SYSERR = 21;
    localparam int B_LOCAL_TO_PCI = 20;
    localparam int B_MAILBOX_LO = 16;
    localparam int B_MAILBOX_HI = 19;
    localparam int B_LOCAL_PARITY = 15;
    localparam int B_POWER_CHANGE = 14;
    localparam int B_OUT_POST_NONEMPTY = 13;
    localparam int B_IN_POST_NEWENTRY = 12;
    localparam int B_IN_FREE_EMPTY = 11;
    localparam int B_OUT_FREE_EMPTY = 10;
    localparam int B_IN_POST_FULL = 9;
    localparam int B_OUT_FREE_FULL = 8;
    localparam int B_SOFT_ONE = 1;
    localparam int B_SOFT_ZERO = 0;
    localparam int PIN_SHIFT = 20;

endpackage

// [rtl/bridge_interrupt_enable_route.sv]
`timescale 1ns/10ps
`default_nettype none

module bridge_interrupt_enable_route (
    // Clock and reset
    input wire logic clk,
    input wire logic nrst,
    // Register port
    input wire logic [11:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [31:0] rdata,
    // Source status levels from the status register
    input wire logic [31:0] src_status,
    input wire logic out_post_irq_mask,
    // Software interrupt set pulses to the status register
    output logic soft_irq_zero_trigger,
    output logic soft_irq_one_trigger,
    // Interrupt pins from the buses, active low
    input wire logic pci_inta_n,
    input wire logic pci_perr_n,
    input wire logic pci_serr_n,
    input wire logic local_int_n,
    // Interrupt outputs, active high levels
    output logic local_irq,
    output logic pci_irq
);

    // ****************************************************************
    // Reset release
    // ****************************************************************
    logic [1:0] rst_pipe;
    logic rst_sync_n;

    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
        begin
            rst_pipe <= 2'h0;
        end
        else
        begin
            rst_pipe <= {rst_pipe[0], 1'b1};
        end
    end

    assign rst_sync_n = rst_pipe[1];

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [3:0] pin_s1;
        logic [3:0] pin_s2;
        logic [31:0] enable;
        logic [31:0] route;
        logic [31:0] rdata;
        logic [1:0] soft_set;
        logic local_irq;
        logic pci_irq;
    } state_t;

    state_t st;
    state_t next_st;

    logic [31:0] enable_rd;
    logic [31:0] route_rd;
    logic [31:0] status_eff;
    logic [31:0] enable_eff;
    logic [31:0] local_hit;
    logic [31:0] pci_hit;
    logic local_req;
    logic pci_req;
    logic wr_enable;
    logic wr_route;

    // ****************************************************************
    // Register views
    // ****************************************************************
    always_comb
    begin
        enable_rd = st.enable & irq_route_pkg::ENABLE_RW_MASK;
        enable_rd[irq_route_pkg::B_OUT_POST_NONEMPTY] = out_post_irq_mask;
        route_rd = (st.route & irq_route_pkg::ROUTE_RW_MASK) | irq_route_pkg::ROUTE_FIXED;
        status_eff = (src_status & irq_route_pkg::EXT_SRC_MASK)
            | ({28'h0000000, st.pin_s2} << irq_route_pkg::PIN_SHIFT);
        enable_eff = (enable_rd & irq_route_pkg::GATED_SRC_MASK)
            | irq_route_pkg::SOFT_SRC_MASK;
    end

    assign wr_enable = wr && (addr == irq_route_pkg::OFS_ENABLE);
    assign wr_route = wr && (addr == irq_route_pkg::OFS_ROUTE);

    irq_route_merge #(
        .N(32)
    ) u_merge (
        .status(status_eff),
        .enable(enable_eff),
        .route(route_rd),
        .local_hit(local_hit),
        .pci_hit(pci_hit),
        .local_req(local_req),
        .pci_req(pci_req)
    );

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb
    begin
        next_st = st;
        next_st.pin_s1 = ~{pci_inta_n, pci_perr_n, pci_serr_n, local_int_n};
        next_st.pin_s2 = st.pin_s1;
        next_st.soft_set = 2'h0;
        next_st.rdata = 32'h00000000;
        if (wr_enable)
        begin
            next_st.enable = wdata & irq_route_pkg::ENABLE_RW_MASK;
            next_st.soft_set[irq_route_pkg::B_SOFT_ONE] = wdata[irq_route_pkg::B_SOFT_ONE];
            next_st.soft_set[irq_route_pkg::B_SOFT_ZERO] = wdata[irq_route_pkg::B_SOFT_ZERO];
        end
        if (wr_route)
        begin
            next_st.route = wdata & irq_route_pkg::ROUTE_RW_MASK;
        end
        if (rd)
        begin
            case (addr)
                irq_route_pkg::OFS_ENABLE:
                begin
                    next_st.rdata = enable_rd;
                end
                irq_route_pkg::OFS_ROUTE:
                begin
                    next_st.rdata = route_rd;
                end
                default:
                begin
                    next_st.rdata = 32'h00000000;
                end
            endcase
        end
        next_st.local_irq = local_req;
        next_st.pci_irq = pci_req;
    end

    always_ff @(posedge clk or negedge rst_sync_n)
    begin
        if (!rst_sync_n)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rdata = st.rdata;
    assign soft_irq_zero_trigger = st.soft_set[irq_route_pkg::B_SOFT_ZERO];
    assign soft_irq_one_trigger = st.soft_set[irq_route_pkg::B_SOFT_ONE];
    assign local_irq = st.local_irq;
    assign pci_irq = st.pci_irq;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_sync_n);

    sequence s_inta_held;
        (!pci_inta_n && st.enable[irq_route_pkg::B_PASS_INT]) [*3];
    endsequence

    sequence s_local_in_held;
        (!local_int_n && st.enable[irq_route_pkg::B_LOCAL_TO_PCI]) [*3];
    endsequence

    sequence s_syserr_held;
        (!pci_serr_n && st.enable[irq_route_pkg::B_PASS_SYSERR]) [*3];
    endsequence

    a_errlog_gate: assert property (
        !st.enable[irq_route_pkg::B_PCI_ERRLOG] && !st.enable[irq_route_pkg::B_LOCAL_ERRLOG]
        |-> !(local_hit[31] | pci_hit[31] | local_hit[30] | pci_hit[30]))
        else $error("Error log interrupt mapped while disabled.");

    a_dma_gate: assert property (
        ((local_hit | pci_hit) & ~st.enable & 32'hFF000000) == 32'h00000000)
        else $error("Bus or DMA interrupt mapped while disabled.");

    a_list_gate: assert property (
        src_status[irq_route_pkg::B_IN_FREE_EMPTY] && st.enable[irq_route_pkg::B_IN_FREE_EMPTY]
        |-> (local_hit[11] != pci_hit[11]))
        else $error("Enabled free list empty interrupt not mapped.");

    a_pass_through: assert property (s_inta_held |=> local_irq)
        else $error("PCI interrupt input not forwarded.");

    a_syserr_fwd: assert property (s_syserr_held |=> local_irq)
        else $error("System error input not forwarded.");

    a_local_to_pci: assert property (s_local_in_held |=> pci_irq)
        else $error("Local interrupt input not forwarded to PCI.");

    a_mask_mirror: assert property (
        rd && addr == irq_route_pkg::OFS_ENABLE
        |=> rdata[13] == $past(out_post_irq_mask) && rdata[1:0] == 2'h0)
        else $error("Enable read shows wrong mirror or trigger bits.");

    a_soft_trigger: assert property (
        wr_enable && wdata[0]
        |=> soft_irq_zero_trigger ##1 (soft_irq_zero_trigger == $past(wr_enable && wdata[0])))
        else $error("Software trigger pulse missing or too long.");

    a_route_split: assert property (
        (local_hit & route_rd) == 32'h00000000 && (pci_hit & ~route_rd) == 32'h00000000)
        else $error("Source steered to the wrong output.");

    a_reset_values: assert property (
        $past(!rst_sync_n) |-> st.enable == 32'h00000000 && st.route == 32'h00000000)
        else $error("Enable or route not at reset value.");

    a_output_or: assert property (
        !local_req && !pci_req |=> !local_irq && !pci_irq)
        else $error("Output asserted with no enabled source.");

    // ****************************************************************
    // Further checks
    // ****************************************************************
    sequence s_perr_held;
        (!pci_perr_n && st.enable[irq_route_pkg::B_PASS_PARITY]) [*3];
    endsequence

    sequence s_pins_off;
        (pci_inta_n && pci_perr_n && pci_serr_n && local_int_n) [*3];
    endsequence

    a_perr_fwd: assert property (s_perr_held |=> local_irq)
        else $error("PCI parity error input not forwarded.");

    a_pins_quiet: assert property (
        s_pins_off |-> ((local_hit | pci_hit) & 32'h00F00000) == 32'h00000000)
        else $error("Pass-through source hit with all pins idle.");

    a_pass_gate: assert property (
        ((local_hit | pci_hit) & ~st.enable & 32'h00F00000) == 32'h00000000)
        else $error("Pass-through source mapped while disabled.");

    a_mailbox_gate: assert property (
        ((local_hit | pci_hit) & ~st.enable & 32'h000F0000) == 32'h00000000)
        else $error("Mailbox interrupt mapped while disabled.");

    a_list_enable: assert property (
        ((local_hit | pci_hit) & ~enable_rd & 32'h0000FF00) == 32'h00000000)
        else $error("List or parity interrupt mapped while disabled.");

    a_power_gate: assert property (
        src_status[irq_route_pkg::B_POWER_CHANGE] && !st.enable[irq_route_pkg::B_POWER_CHANGE]
        |-> !local_hit[14] && !pci_hit[14])
        else $error("Power change interrupt mapped while disabled.");

    a_newentry_gate: assert property (
        src_status[irq_route_pkg::B_IN_POST_NEWENTRY] && st.enable[irq_route_pkg::B_IN_POST_NEWENTRY]
        |-> local_hit[12] || pci_hit[12])
        else $error("Enabled new entry interrupt not mapped.");

    a_full_hit: assert property (
        src_status[irq_route_pkg::B_IN_POST_FULL] && st.enable[irq_route_pkg::B_IN_POST_FULL]
        |-> local_hit[9] || pci_hit[9])
        else $error("Enabled post list full interrupt not mapped.");

    a_enable_store: assert property (
        wr_enable |=> st.enable == ($past(wdata) & irq_route_pkg::ENABLE_RW_MASK))
        else $error("Enable write not stored.");

    a_route_store: assert property (
        wr_route |=> st.route == ($past(wdata) & irq_route_pkg::ROUTE_RW_MASK))
        else $error("Route write not stored.");

    a_route_fixed: assert property (
        (route_rd & ~irq_route_pkg::ROUTE_RW_MASK) == irq_route_pkg::ROUTE_FIXED)
        else $error("Fixed route bits wrong.");

    a_read_idle: assert property (
        !rd |=> rdata == 32'h00000000)
        else $error("Read data shown without a read.");

    a_trigger_one: assert property (
        wr_enable && wdata[1] |=> soft_irq_one_trigger)
        else $error("Software trigger one pulse missing.");

    a_trigger_quiet: assert property (
        !wr_enable |=> !soft_irq_zero_trigger && !soft_irq_one_trigger)
        else $error("Software trigger pulse without a write.");

    a_local_level: assert property (
        local_req |=> local_irq)
        else $error("Local output missing with a steered source.");

    a_pci_level: assert property (
        pci_req |=> pci_irq)
        else $error("PCI output missing with a steered source.");

    a_soft_ungated: assert property (
        (status_eff[3:0] & ~route_rd[3:0]) != 4'h0 |-> local_req)
        else $error("Software interrupt not steered to local output.");

endmodule // bridge_interrupt_enable_route

`default_nettype wire

// [rtl/irq_route_merge.sv]
`timescale 1ns/10ps
`default_nettype none

module irq_route_merge #(
    parameter int N = 32
) (
    // Source levels and settings
    input wire logic [N-1:0] status,
    input wire logic [N-1:0] enable,
    input wire logic [N-1:0] route,
    // Per-source hits and merged requests
    output logic [N-1:0] local_hit,
    output logic [N-1:0] pci_hit,
    output logic local_req,
    output logic pci_req
);

    // ****************************************************************
    // Per-source gating and steering
    // ****************************************************************
    genvar i;
    generate
        for (i = 0; i < N; i++)
        begin : g_src
            assign local_hit[i] = status[i] & enable[i] & ~route[i];
            assign pci_hit[i] = status[i] & enable[i] & route[i];
        end
    endgenerate

    assign local_req = |local_hit;
    assign pci_req = |pci_hit;

endmodule // irq_route_merge

`default_nettype wire

// [verification/irq_pin_model.sv]
`timescale 1ns/10ps
`default_nettype none

module irq_pin_model (
    // Clock and requests
    input wire logic clk,
    input wire logic [3:0] req,
    input wire logic [1:0] lag,
    // Active low pins, pulled up while released
    output logic [3:0] pin_n
);
    logic [3:0] dly [0:2] = '{default: 4'h0};

    // A late answer is the request seen through up to three stages.
    always @(posedge clk)
    begin
        dly[0] <= req;
        dly[1] <= dly[0];
        dly[2] <= dly[1];
    end
    assign pin_n = ~((lag == 2'h0) ? req : dly[lag - 2'h1]);
endmodule // irq_pin_model

`default_nettype wire

// [verification/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none

module tb_top;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic [11:0] addr = 12'h000;
    logic [31:0] wdata = 32'h00000000;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [31:0] st = 32'h00000000;
    logic mask = 1'b0;
    logic [3:0] req = 4'h0;
    logic [1:0] lag = 2'h0;
    logic [3:0] pin_n;
    logic [31:0] rdata;
    logic t0;
    logic t1;
    logic lirq;
    logic pirq;
    logic rd_pend = 1'b0;
    logic [31:0] q [$];
    logic [31:0] ev;
    logic [31:0] rt;
    int n_mismatch = 0;
    int checks = 0;
    int seed = 46;
    event got_t;
    event got_i;

    always #25 clk = ~clk;

    bridge_interrupt_enable_route u_dut (.clk(clk), .nrst(nrst), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .src_status(st),
        .out_post_irq_mask(mask), .soft_irq_zero_trigger(t0),
        .soft_irq_one_trigger(t1), .pci_inta_n(pin_n[3]), .pci_perr_n(pin_n[2]),
        .pci_serr_n(pin_n[1]), .local_int_n(pin_n[0]), .local_irq(lirq), .pci_irq(pirq));

    irq_pin_model u_pins (.clk(clk), .req(req), .lag(lag), .pin_n(pin_n));

    task automatic test_done();
        $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] g);
        logic [31:0] e;
        e = q.pop_front();
        checks++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // ****************************************************************
    // Result watcher
    // ****************************************************************
    always @(negedge clk)
    begin
        if (rd_pend)
            cmp(rdata);
        rd_pend = rd;
    end
    always @(got_t) cmp({30'h0, t1, t0});
    always @(got_i) cmp({30'h0, lirq, pirq});

    // ****************************************************************
    // Drivers
    // ****************************************************************
    task automatic wreg(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        @(negedge clk);
        q.push_back({30'h0, d[1:0] & {2{a == irq_route_pkg::OFS_ENABLE}}});
        -> got_t;
    endtask

    task automatic rreg(input logic [11:0] a, input logic [31:0] e);
        q.push_back(e);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        @(negedge clk);
    endtask

    task automatic drive(input logic [31:0] s, input logic m, input logic [3:0] r);
        @(posedge clk);
        st <= s;
        mask <= m;
        req <= r;
    endtask

    task automatic chk_irq(input int n, input logic [1:0] e);
        repeat (n) @(posedge clk);
        @(negedge clk);
        q.push_back({30'h0, e});
        -> got_i;
    endtask

    function automatic logic [1:0] xirq(input logic [31:0] s, en, r, input logic m);
        logic [31:0] ee;
        logic [31:0] rr;
        logic [31:0] h;
        ee = (en & irq_route_pkg::ENABLE_RW_MASK) | irq_route_pkg::SOFT_SRC_MASK;
        ee = ee | ({31'h0, m} << 13);
        rr = (r & irq_route_pkg::ROUTE_RW_MASK) | irq_route_pkg::ROUTE_FIXED;
        h = s & ee & (irq_route_pkg::EXT_SRC_MASK | 32'h00F00000);
        return {|(h & ~rr), |(h & rr)};
    endfunction

    initial
    begin
        #1000000;
        n_mismatch++;
        test_done();
    end

    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial
    begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(irq_route_pkg::OFS_ENABLE, irq_route_pkg::ENABLE_RESET);
        rreg(irq_route_pkg::OFS_ROUTE, irq_route_pkg::ROUTE_FIXED);
        wreg(12'h700, 32'hFFFFFFFF);
        rreg(12'h700, 32'h00000000);
        drive(32'h0, 1'b1, 4'h0);
        wreg(irq_route_pkg::OFS_ENABLE, 32'hFFFFFFFF);
        rreg(irq_route_pkg::OFS_ENABLE, 32'hFFFFFF00);
        wreg(irq_route_pkg::OFS_ENABLE, 32'h00000002);
        wreg(irq_route_pkg::OFS_ROUTE, 32'hFFFFFFFF);
        rreg(irq_route_pkg::OFS_ROUTE, 32'hFF1FAF0F);
        for (int i = 0; i < 32; i++)
            if (irq_route_pkg::EXT_SRC_MASK[i])
            begin
                rt = $random(seed);
                for (int en = 0; en < 2; en++)
                begin
                    ev = {32{en[0]}};
                    drive(32'h1 << i, en[0], 4'h0);
                    wreg(irq_route_pkg::OFS_ENABLE, ev);
                    wreg(irq_route_pkg::OFS_ROUTE, rt);
                    chk_irq(1, xirq(32'h1 << i, ev, rt, en[0]));
                end
            end
        for (int j = 0; j < 4; j++)
        begin
            lag <= j[1:0];
            drive(32'h0, 1'b0, 4'h1 << j);
            wreg(irq_route_pkg::OFS_ENABLE, 32'hFFFFFFFC);
            chk_irq(6, xirq(32'h1 << (20 + j), 32'hFFFFFFFC, 32'h0, 1'b0));
            wreg(irq_route_pkg::OFS_ENABLE, 32'h00000000);
            chk_irq(4, 2'b00);
        end
        lag <= 2'h0;
        drive(32'h80000000, 1'b0, 4'h1);
        wreg(irq_route_pkg::OFS_ENABLE, 32'hFFFFFFFC);
        wreg(irq_route_pkg::OFS_ROUTE, 32'h00000000);
        chk_irq(6, 2'b11);
        @(posedge clk);
        nrst <= 1'b0;
        chk_irq(2, 2'b00);
        drive(32'h80000000, 1'b0, 4'h0);
        nrst <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(irq_route_pkg::OFS_ENABLE, 32'h00000000);
        rreg(irq_route_pkg::OFS_ROUTE, irq_route_pkg::ROUTE_FIXED);
        chk_irq(1, 2'b00);
        test_done();
    end
endmodule // tb_top

`default_nettype wire
